// ---- logic/jpe_pkg.sv ----
// Constants and types for the scan-port program entry block
package jpe_pkg;

    // Instruction register
    localparam int unsigned JPE_IR_W          = 4;
    localparam logic [3:0]  JPE_OP_CORE_RESET = 4'hc;
    localparam logic [3:0]  JPE_OP_PROG_ENTRY = 4'h4;
    localparam logic [3:0]  JPE_OP_BYPASS     = 4'hf;
    localparam logic [3:0]  JPE_IR_CAPTURE    = 4'h1;

    // Programming-enable register
    localparam int unsigned JPE_PE_W          = 16;
    localparam logic [15:0] JPE_PE_SIGNATURE  = 16'ha370;
    localparam logic [15:0] JPE_PE_RESET      = 16'h0000;

    // Register port
    localparam int unsigned JPE_ADDR_W        = 4;
    localparam int unsigned JPE_DATA_W        = 8;
    localparam logic [3:0]  JPE_ADDR_MCU_CTRL = 4'h0;
    localparam logic [3:0]  JPE_ADDR_STATUS   = 4'h1;
    localparam int unsigned JPE_DISABLE_BIT   = 7;
    localparam int unsigned JPE_ST_PROG_BIT   = 0;
    localparam int unsigned JPE_ST_CRST_BIT   = 1;
    localparam int unsigned JPE_ST_USABLE_BIT = 2;
    localparam int unsigned JPE_ST_IR_LSB     = 4;

    // Chip clocks of external reset low before the disable bit clears
    localparam logic [1:0]  JPE_REARM_CYCLES  = 2'h2;

    typedef enum logic [15:0] {
        JPE_TLR        = 16'h0001,
        JPE_RTI        = 16'h0002,
        JPE_SEL_DR     = 16'h0004,
        JPE_CAPTURE_DR = 16'h0008,
        JPE_SHIFT_DR   = 16'h0010,
        JPE_EXIT1_DR   = 16'h0020,
        JPE_PAUSE_DR   = 16'h0040,
        JPE_EXIT2_DR   = 16'h0080,
        JPE_UPDATE_DR  = 16'h0100,
        JPE_SEL_IR     = 16'h0200,
        JPE_CAPTURE_IR = 16'h0400,
        JPE_SHIFT_IR   = 16'h0800,
        JPE_EXIT1_IR   = 16'h1000,
        JPE_PAUSE_IR   = 16'h2000,
        JPE_EXIT2_IR   = 16'h4000,
        JPE_UPDATE_IR  = 16'h8000
    } jpe_tap_t;

    typedef struct packed {
        jpe_tap_t        tap;
        logic [3:0]      ir_sr;
        logic [3:0]      ir;
        logic [15:0]     pe_sr;
        logic            prog_mode;
        logic            rst_chain;
        logic            bypass;
        logic            tdo;
        logic            tdo_oe;
        logic            prog_clk;
        logic            tck_prev;
        logic            disable_bit;
        logic [1:0]      ext_lo_cnt;
        logic [7:0]      rdata;
    } jpe_state_t;

endpackage : jpe_pkg

// ---- logic/jpe_sync.sv ----
// Two-flop synchroniser for a vector of levels
`timescale 1ns/1ns
module jpe_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : jpe_sync

// ---- logic/jpe_top.sv ----
// Scan-port front end: TAP, instruction register, core reset and program entry
// Behaviour
// - Scan port works only while the enable fuse is programmed.
// - Scan port works only while the port-disable bit is clear.
// - Disable bit set and external reset low: bit clears after two chip clocks.
// - All shift registers shift least significant bit first, in and out.
// - Four-bit instruction register selects the data register between in and out.
// - Run-Test/Idle generates internal programming clocks and serves as idle.
// - Opcode 0xc puts the one-bit core reset chain in the path.
// - Core reset never disturbs the TAP controller state.
// - Opcode 0x4 selects the sixteen-bit programming-enable register.
// - Update-DR under 0x4 enters programming mode only on exact signature.
// - Programming-enable register clears on power-on reset; programmer clears later.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module jpe_top
    import jpe_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  tck_i,
    input  wire logic                  tms_i,
    input  wire logic                  tdi_i,
    input  wire logic                  ext_reset_n_i,
    input  wire logic                  scan_port_enable_fuse_i,
    input  wire logic [JPE_ADDR_W-1:0] addr_i,
    input  wire logic [JPE_DATA_W-1:0] wdata_i,
    input  wire logic                  we_i,
    input  wire logic                  re_i,
    output logic      [JPE_DATA_W-1:0] rdata_o,
    output logic                       tdo_o,
    output logic                       tdo_oe_o,
    output logic                       core_reset_o,
    output logic                       prog_mode_o,
    output logic                       prog_clk_o
);
    logic       rst_sync;
    logic [3:0] pins_s;
    logic       tck_s;
    logic       tms_s;
    logic       tdi_s;
    logic       ext_n_s;
    logic       usable;
    logic       tck_rise;
    logic       tck_fall;
    jpe_state_t q;
    jpe_state_t d;

    jpe_sync #(.W(1)) u_rst_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (1'b1),
        .q_o     (rst_sync)
    );

    jpe_sync #(.W(4)) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_sync),
        .d_i     ({ext_reset_n_i, tdi_i, tms_i, tck_i}),
        .q_o     (pins_s)
    );

    assign tck_s    = pins_s[0];
    assign tms_s    = pins_s[1];
    assign tdi_s    = pins_s[2];
    assign ext_n_s  = pins_s[3];
    assign usable   = scan_port_enable_fuse_i & ~q.disable_bit;
    assign tck_rise = tck_s & ~q.tck_prev;
    assign tck_fall = ~tck_s & q.tck_prev;

    function automatic jpe_tap_t jpe_tap_next(input jpe_tap_t s, input logic tms);
        case (s)
            JPE_TLR:        jpe_tap_next = tms ? JPE_TLR       : JPE_RTI;
            JPE_RTI:        jpe_tap_next = tms ? JPE_SEL_DR    : JPE_RTI;
            JPE_SEL_DR:     jpe_tap_next = tms ? JPE_SEL_IR    : JPE_CAPTURE_DR;
            JPE_CAPTURE_DR: jpe_tap_next = tms ? JPE_EXIT1_DR  : JPE_SHIFT_DR;
            JPE_SHIFT_DR:   jpe_tap_next = tms ? JPE_EXIT1_DR  : JPE_SHIFT_DR;
            JPE_EXIT1_DR:   jpe_tap_next = tms ? JPE_UPDATE_DR : JPE_PAUSE_DR;
            JPE_PAUSE_DR:   jpe_tap_next = tms ? JPE_EXIT2_DR  : JPE_PAUSE_DR;
            JPE_EXIT2_DR:   jpe_tap_next = tms ? JPE_UPDATE_DR : JPE_SHIFT_DR;
            JPE_UPDATE_DR:  jpe_tap_next = tms ? JPE_SEL_DR    : JPE_RTI;
            JPE_SEL_IR:     jpe_tap_next = tms ? JPE_TLR       : JPE_CAPTURE_IR;
            JPE_CAPTURE_IR: jpe_tap_next = tms ? JPE_EXIT1_IR  : JPE_SHIFT_IR;
            JPE_SHIFT_IR:   jpe_tap_next = tms ? JPE_EXIT1_IR  : JPE_SHIFT_IR;
            JPE_EXIT1_IR:   jpe_tap_next = tms ? JPE_UPDATE_IR : JPE_PAUSE_IR;
            JPE_PAUSE_IR:   jpe_tap_next = tms ? JPE_EXIT2_IR  : JPE_PAUSE_IR;
            JPE_EXIT2_IR:   jpe_tap_next = tms ? JPE_UPDATE_IR : JPE_SHIFT_IR;
            JPE_UPDATE_IR:  jpe_tap_next = tms ? JPE_SEL_DR    : JPE_RTI;
            default:        jpe_tap_next = JPE_TLR;
        endcase
    endfunction : jpe_tap_next

    always_comb begin
        d          = q;
        d.tck_prev = tck_s;
        d.prog_clk = 1'b0;
        d.rdata    = '0;

        // Port-disable re-enable through external reset
        if (q.disable_bit && !ext_n_s) begin
            if (q.ext_lo_cnt == JPE_REARM_CYCLES - 2'h1) begin
                d.disable_bit = 1'b0;
                d.ext_lo_cnt  = '0;
            end else begin
                d.ext_lo_cnt = q.ext_lo_cnt + 2'h1;
            end
        end else begin
            d.ext_lo_cnt = '0;
        end

        // Software write applied last, so a set wins over the reset clear
        if (we_i && addr_i == JPE_ADDR_MCU_CTRL) begin
            d.disable_bit = wdata_i[JPE_DISABLE_BIT];
        end

        if (re_i) begin
            case (addr_i)
                JPE_ADDR_MCU_CTRL: d.rdata[JPE_DISABLE_BIT] = q.disable_bit;
                JPE_ADDR_STATUS: begin
                    d.rdata[JPE_ST_PROG_BIT]               = q.prog_mode;
                    d.rdata[JPE_ST_CRST_BIT]               = q.rst_chain;
                    d.rdata[JPE_ST_USABLE_BIT]             = usable;
                    d.rdata[JPE_ST_IR_LSB +: JPE_IR_W]     = q.ir;
                end
                default: d.rdata = '0;
            endcase
        end

        if (!usable) begin
            d.tap    = JPE_TLR;
            d.ir     = JPE_OP_BYPASS;
            d.tdo_oe = 1'b0;
        end else if (tck_rise) begin
            case (q.tap)
                JPE_TLR: d.ir = JPE_OP_BYPASS;
                JPE_RTI: d.prog_clk = 1'b1;
                JPE_CAPTURE_DR: d.bypass = 1'b0;
                JPE_SHIFT_DR: begin
                    case (q.ir)
                        JPE_OP_CORE_RESET: d.rst_chain = tdi_s;
                        JPE_OP_PROG_ENTRY: d.pe_sr = {tdi_s, q.pe_sr[15:1]};
                        default:           d.bypass = tdi_s;
                    endcase
                end
                JPE_UPDATE_DR: begin
                    if (q.ir == JPE_OP_PROG_ENTRY) begin
                        d.prog_mode = (q.pe_sr == JPE_PE_SIGNATURE);
                    end
                end
                JPE_CAPTURE_IR: d.ir_sr = JPE_IR_CAPTURE;
                JPE_SHIFT_IR:   d.ir_sr = {tdi_s, q.ir_sr[3:1]};
                JPE_UPDATE_IR:  d.ir = q.ir_sr;
                default: d.ir = q.ir;
            endcase
            // Controller advances on the scan clock only; core reset never touches it
            d.tap = jpe_tap_next(q.tap, tms_s);
        end else if (tck_fall) begin
            d.tdo_oe = (q.tap == JPE_SHIFT_DR) || (q.tap == JPE_SHIFT_IR);
            if (q.tap == JPE_SHIFT_IR) begin
                d.tdo = q.ir_sr[0];
            end else begin
                case (q.ir)
                    JPE_OP_CORE_RESET: d.tdo = q.rst_chain;
                    JPE_OP_PROG_ENTRY: d.tdo = q.pe_sr[0];
                    default:           d.tdo = q.bypass;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            q             <= '0;
            q.tap         <= JPE_TLR;
            q.ir          <= JPE_OP_BYPASS;
            q.pe_sr       <= JPE_PE_RESET;
        end else begin
            q <= d;
        end
    end

    assign rdata_o      = q.rdata;
    assign tdo_o        = q.tdo;
    assign tdo_oe_o     = q.tdo_oe;
    assign core_reset_o = q.rst_chain;
    assign prog_mode_o  = q.prog_mode;
    assign prog_clk_o   = q.prog_clk;

    chk_port_gate: assert property (@(posedge clk_i) disable iff (!rst_sync)
        !usable |=> (q.tap == JPE_TLR) && !tdo_oe_o)
        else $error("scan port active while not usable");

    chk_rearm_clear: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (q.disable_bit && !ext_n_s && !we_i)[*2] |=> !q.disable_bit)
        else $error("disable bit not cleared after two clocks");

    chk_rearm_hold: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (q.disable_bit && ext_n_s && !we_i) |=> q.disable_bit)
        else $error("disable bit lost without reset");

    chk_pe_shift: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (usable && tck_rise && q.tap == JPE_SHIFT_DR && q.ir == JPE_OP_PROG_ENTRY)
        |=> (q.pe_sr[15] == $past(tdi_s)) && (q.pe_sr[14:0] == $past(q.pe_sr[15:1])))
        else $error("enable register not shifted lsb first");

    chk_ir_load: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (usable && tck_rise && q.tap == JPE_UPDATE_IR) |=> q.ir == $past(q.ir_sr))
        else $error("instruction not loaded on update");

    chk_idle_clock: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (usable && tck_rise && q.tap == JPE_RTI) |=> prog_clk_o ##1 !prog_clk_o)
        else $error("idle clock pulse missing");

    chk_reset_chain: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (usable && tck_rise && q.tap == JPE_SHIFT_DR && q.ir == JPE_OP_CORE_RESET)
        |=> core_reset_o == $past(tdi_s))
        else $error("core reset does not follow chain");

    chk_tap_stable: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (usable && !tck_rise && q.tap != JPE_TLR) |=> $stable(q.tap))
        else $error("controller moved without scan clock");

    chk_sig_match: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (usable && tck_rise && q.tap == JPE_UPDATE_DR && q.ir == JPE_OP_PROG_ENTRY)
        |=> prog_mode_o == ($past(q.pe_sr) == JPE_PE_SIGNATURE))
        else $error("program mode does not match signature");

    chk_bypass_bit: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (usable && tck_rise && q.tap == JPE_SHIFT_DR && q.ir != JPE_OP_PROG_ENTRY
         && q.ir != JPE_OP_CORE_RESET) |=> q.bypass == $past(tdi_s))
        else $error("bypass bit not shifted");

endmodule : jpe_top

// ---- test/jpe_prog_model.sv ----
// Scan programmer model driving the three scan input pins of the block and sampling its data-out pin
`timescale 1ns/1ns
module jpe_prog_model (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One link clock period; clock stands low between frames
    task automatic bit_io(input logic ms, input logic di, output logic dout);
        tms_o <= ms;
        tdi_o <= di;
        #160 tck_o <= 1'b1;
        #150 dout = tdo_i;
        #10 tck_o <= 1'b0;
    endtask : bit_io

    task automatic tap_reset();
        logic d;
        repeat (5) bit_io(1'b1, 1'b0, d);
        bit_io(1'b0, 1'b0, d);
    endtask : tap_reset

    task automatic idle(input int n);
        logic d;
        repeat (n) bit_io(1'b0, 1'b0, d);
    endtask : idle

    // From idle, scan n bits through IR or DR and return to idle
    task automatic shift(input logic is_ir, input int n, input logic [15:0] din,
                         output logic [15:0] dout);
        logic d;
        dout = '0;
        bit_io(1'b1, 1'b0, d);
        if (is_ir) begin
            bit_io(1'b1, 1'b0, d);
        end
        bit_io(1'b0, 1'b0, d);
        bit_io(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            bit_io(i == n - 1, din[i], d);
            dout[i] = d;
        end
        bit_io(1'b1, 1'b0, d);
        bit_io(1'b0, 1'b0, d);
        tdi_o <= ~tdi_o;
    endtask : shift
endmodule : jpe_prog_model

// ---- test/jpe_top_tb_top.sv ----
// Testbench for the scan-port program entry block
`timescale 1ns/1ns
module jpe_top_tb_top;
    import jpe_pkg::*;
    logic                  clk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic                  tck, tms, tdi;
    logic                  ext_reset_n_i = 1'b1;
    logic                  fuse = 1'b1;
    logic [JPE_ADDR_W-1:0] addr_i = '0;
    logic [JPE_DATA_W-1:0] wdata_i = '0;
    logic                  we_i = 1'b0;
    logic                  re_i = 1'b0;
    logic [JPE_DATA_W-1:0] rdata_o;
    logic                  tdo_o, tdo_oe_o, core_reset_o, prog_mode_o, prog_clk_o;
    logic [15:0]           dout;
    int                    failures = 0;
    int                    check_count = 0;
    int                    pclk_n = 0;

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (prog_clk_o === 1'b1) pclk_n++;

    jpe_top jpe_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .ext_reset_n_i(ext_reset_n_i), .scan_port_enable_fuse_i(fuse),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .core_reset_o(core_reset_o),
        .prog_mode_o(prog_mode_o), .prog_clk_o(prog_clk_o));

    // Released data-out line floats high
    jpe_prog_model jpe_prog_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .tdo_i(tdo_oe_o ? tdo_o : 1'b1));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge clk_i);
        we_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge clk_i);
        re_i   <= 1'b0;
        #1 chk({8'h00, rdata_o}, {8'h00, exp});
    endtask : rd

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        #1_000_000;
        failures++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd(JPE_ADDR_STATUS, 8'hf4);
        rd(JPE_ADDR_MCU_CTRL, 8'h00);
        wr(4'h5, 8'hff);
        rd(4'h5, 8'h00);
        $display("test reset_values done");
        jpe_prog_model_inst.tap_reset();
        jpe_prog_model_inst.shift(1'b1, 4, 16'h000c, dout);
        chk(dout, 16'h0001);
        jpe_prog_model_inst.shift(1'b0, 1, 16'h0001, dout);
        chk(core_reset_o, 1'b1);
        rd(JPE_ADDR_STATUS, 8'hc6);
        jpe_prog_model_inst.shift(1'b0, 1, 16'h0000, dout);
        chk(dout, 16'h0001);
        chk(core_reset_o, 1'b0);
        jpe_prog_model_inst.shift(1'b0, 1, 16'h0001, dout);
        $display("test core_reset done");
        jpe_prog_model_inst.shift(1'b1, 4, 16'h0004, dout);
        jpe_prog_model_inst.shift(1'b0, 16, 16'ha371, dout);
        chk(dout, JPE_PE_RESET);
        chk(prog_mode_o, 1'b0);
        jpe_prog_model_inst.shift(1'b0, 16, JPE_PE_SIGNATURE, dout);
        chk(dout, 16'ha371);
        chk(prog_mode_o, 1'b1);
        rd(JPE_ADDR_STATUS, 8'h47);
        pclk_n = 0;
        jpe_prog_model_inst.idle(5);
        chk(pclk_n[15:0], 16'h0005);
        jpe_prog_model_inst.shift(1'b0, 16, 16'h0000, dout);
        chk(dout, JPE_PE_SIGNATURE);
        chk(prog_mode_o, 1'b0);
        $display("test program_entry done");
        jpe_prog_model_inst.shift(1'b1, 4, 16'h0003, dout);
        jpe_prog_model_inst.shift(1'b0, 4, 16'h000b, dout);
        chk(dout, 16'h0006);
        $display("test bypass done");
        wr(JPE_ADDR_MCU_CTRL, 8'h80);
        rd(JPE_ADDR_MCU_CTRL, 8'h80);
        rd(JPE_ADDR_STATUS, 8'hf2);
        jpe_prog_model_inst.shift(1'b1, 4, 16'h0004, dout);
        rd(JPE_ADDR_STATUS, 8'hf2);
        @(posedge clk_i);
        ext_reset_n_i <= 1'b0;
        @(posedge clk_i);
        ext_reset_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(JPE_ADDR_MCU_CTRL, 8'h80);
        @(posedge clk_i);
        ext_reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        ext_reset_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(JPE_ADDR_MCU_CTRL, 8'h00);
        rd(JPE_ADDR_STATUS, 8'hf6);
        $display("test disable_bit done");
        @(posedge clk_i);
        fuse <= 1'b0;
        jpe_prog_model_inst.tap_reset();
        jpe_prog_model_inst.shift(1'b1, 4, 16'h0004, dout);
        rd(JPE_ADDR_STATUS, 8'hf2);
        @(posedge clk_i);
        fuse <= 1'b1;
        jpe_prog_model_inst.tap_reset();
        jpe_prog_model_inst.shift(1'b1, 4, 16'h0004, dout);
        rd(JPE_ADDR_STATUS, 8'h46);
        $display("test enable_fuse done");
        stop_test();
    end
endmodule : jpe_top_tb_top
